/* File: verilog/sps_defines.svh */
// Functional notes
// RQ1: A10 picks one bank or all on precharge
// RQ2: All-bank precharge ignores bank select bits
// RQ3: Controller waits precharge, activates before access
// RQ4: CKE low with NOP, no access: power-down
// RQ5: Power-down turns buffers off, no refresh
// RQ6: Controller keeps power-down under 64 ms
// RQ7: CKE high with NOP exits power-down
// RQ8: CKE low during burst enters clock suspend
// RQ9: Low CKE skips next edge, holds state
// RQ10: CKE high resumes; next command at n+1
// RQ11: Write burst mode bit forces single writes
// RQ12: Read cuts auto-precharge read, precharge now
// RQ13: Write cuts auto-precharge read, precharge now
// RQ14: Read cuts auto-precharge write, precharge after recovery
// RQ15: Write cuts auto-precharge write, precharge after recovery
// RQ16: Burst terminate with CKE low: deep power-down
// RQ17: Controller runs full init after deep power-down
// RQ18: Self refresh exit needs time and two NOPs
// RQ19: CKE falling selects self refresh or suspend
// RQ20: Command decode from chip select and strobes
// RQ21: Refresh and mode load only when idle
// RQ22: Precharge to idle bank is a no-op
// RQ23: Decode only when CKE high twice
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
// Register byte offsets
`define SPS_REG_CFG       8'h00
`define SPS_REG_STAT      8'h04
`define SPS_REG_MODE      8'h08
// Configuration fields and reset value
`define SPS_CFG_TRP_LSB   0
`define SPS_CFG_TWR_LSB   4
`define SPS_CFG_SELF_REFRESH_EXIT_TIME_LSB  8
`define SPS_CFG_RST       32'h0000_0A22
// Address fields
`define SPS_AW            13
`define SPS_AP_BIT        10
`define SPS_MR_WBM_BIT    9
`define SPS_MR_FULL       3'h7
// Timing
`define SPS_CLK_NS        100
`define SPS_DPD_MIN_US    100
`define SPS_DPD_MIN_CYC   ((`SPS_DPD_MIN_US * 1000 + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_REF_PERIOD_MS 64
`define SPS_PDN_LIMIT_CYC ((`SPS_REF_PERIOD_MS * 1000000) / `SPS_CLK_NS)
`endif

/* File: verilog/sps_pkg.sv */
package sps_pkg;
  typedef enum logic [3:0] {
    SPS_INH = 4'h0, SPS_NOP = 4'h1, SPS_ACT = 4'h2, SPS_RD  = 4'h3, SPS_WR = 4'h4,
    SPS_BT  = 4'h5, SPS_PRE = 4'h6, SPS_REF = 4'h7, SPS_LMR = 4'h8
  } sps_cmd_t;
  typedef enum logic [2:0] {
    SPS_RUN = 3'h0, SPS_PDN = 3'h1, SPS_SUSP = 3'h2, SPS_SREF = 3'h3,
    SPS_SREF_EXIT = 3'h4, SPS_DPD = 3'h5
  } sps_pstate_t;
  typedef enum logic [1:0] {
    SPS_BK_IDLE = 2'h0, SPS_BK_OPEN = 2'h1, SPS_BK_PRE = 2'h2
  } sps_bk_t;
endpackage

/* File: verilog/sps_cmd_decode.sv */
`timescale 1ns/1ns
module sps_cmd_decode (
  // Command strobes
  input  wire logic             cs_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  // Decoded command
  output sps_pkg::sps_cmd_t     cmd
);
  import sps_pkg::*;

  // Chip select high wins over every strobe
  always_comb begin
    if (cs_n) begin
      cmd = SPS_INH; // RQ20
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'b111: cmd = SPS_NOP; // RQ20
        3'b011: cmd = SPS_ACT; // RQ20
        3'b101: cmd = SPS_RD;
        3'b100: cmd = SPS_WR;
        3'b110: cmd = SPS_BT;
        3'b010: cmd = SPS_PRE; // RQ20
        3'b001: cmd = SPS_REF; // RQ20
        3'b000: cmd = SPS_LMR;
      endcase
    end
  end
endmodule

/* File: verilog/sps_bank.sv */
`timescale 1ns/1ns
module sps_bank (
  // System
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // Control
  input  wire logic             tick,
  input  wire logic             act,
  input  wire logic             pre,
  input  wire logic             flush,
  input  wire logic [3:0]       row_precharge_time,
  // State
  output logic                  open,
  output logic                  idle
);
  import sps_pkg::*;

  sps_bk_t    st;
  sps_bk_t    next_st;
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  // Bank row state; timer only moves on live internal edges
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    if (flush) begin
      next_st = SPS_BK_IDLE;
    end else if (tick) begin
      unique case (st)
        SPS_BK_IDLE: if (act) next_st = SPS_BK_OPEN;
        SPS_BK_OPEN: begin
          if (pre) begin
            next_st  = SPS_BK_PRE;
            next_cnt = row_precharge_time;
          end
        end
        SPS_BK_PRE: begin
          if (cnt <= 4'h1) next_st = SPS_BK_IDLE;
          else next_cnt = cnt - 4'h1;
        end
        default: next_st = SPS_BK_IDLE;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st  <= SPS_BK_IDLE;
      cnt <= 4'h0;
    end else if (ce) begin
      st  <= next_st;
      cnt <= next_cnt;
    end
  end

  assign open = (st == SPS_BK_OPEN);
  assign idle = (st == SPS_BK_IDLE); // RQ22 precharge leaves idle bank alone
endmodule

/* File: verilog/sps_top.sv */
`timescale 1ns/1ns
`include "sps_defines.svh"
module sps_top #(
  parameter int DW            = 32,
  parameter int CL            = 2,
  parameter int CB            = 4,
  parameter int PDN_LIMIT_CYC = `SPS_PDN_LIMIT_CYC
) (
  // System
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                ce,
  // Memory command pins
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [`SPS_AW-1:0]  addr,
  input  wire logic                bank_select_bit0,
  input  wire logic                bank_select_bit1,
  input  wire logic                dqm,
  // Data pins
  input  wire logic [DW-1:0]       dq_in,
  output logic [DW-1:0]            dq_out,
  output logic                     dq_oe_n,
  // Power status
  output logic                     buf_off,
  output logic                     self_refresh,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic [31:0]              hrdata,
  output logic                     hresp
);
  import sps_pkg::*;

  if (CL < 2 || CL > 3 || CB < 1 || CB > 8) begin : g_chk
    $error("sps_top: unsupported CL or CB");
  end

  localparam int AW = CB + 2;

  sps_cmd_t          cmd;
  sps_pstate_t       pstate, next_pstate;
  logic              cke_prev;
  logic [31:0]       cfg, next_cfg;
  logic [2:0]        mode_bl, next_mode_bl;
  logic              mode_wbm, next_mode_wbm;
  logic              brst_on, next_brst_on, brst_wr, next_brst_wr, brst_ap, next_brst_ap;
  logic              brst_full, next_brst_full;
  logic [1:0]        brst_bank, next_brst_bank;
  logic [CB-1:0]     brst_col, next_brst_col;
  logic [7:0]        brst_left, next_brst_left;
  logic              apc_on, next_apc_on;
  logic [1:0]        apc_bank, next_apc_bank;
  logic [3:0]        apc_cnt, next_apc_cnt;
  logic [7:0]        xsr_cnt, next_xsr_cnt;
  logic [1:0]        nop_cnt, next_nop_cnt;
  logic [10:0]       dpd_cnt, next_dpd_cnt;
  logic              dpd_short, next_dpd_short;
  logic [31:0]       pdn_cnt, next_pdn_cnt;
  logic              pdn_over, next_pdn_over;
  logic [CL-1:0]     rd_v, next_rd_v;
  logic [DW-1:0]     rd_d [CL];
  logic [DW-1:0]     next_rd_d [CL];
  logic [DW-1:0]     mem [1 << AW];
  logic              wr_en, rd_push, bk_flush, adv, cmd_ok, nopish;
  logic [AW-1:0]     wr_idx, rd_idx;
  logic [3:0]        bk_act, bk_pre, bk_open, bk_idle;
  logic [1:0]        ba;
  logic              a_wr, a_rd, next_a_wr, next_a_rd;
  logic [7:0]        a_off, next_a_off;
  logic [31:0]       next_hrdata, stat;

  sps_cmd_decode u_dec (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cmd   (cmd)
  );

  // One state machine per bank
  for (genvar b = 0; b < 4; b++) begin : g_bank
    sps_bank u_bank (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .tick   (adv),
      .act    (bk_act[b]),
      .pre    (bk_pre[b]),
      .flush  (bk_flush),
      .row_precharge_time    (cfg[`SPS_CFG_TRP_LSB +: 4]),
      .open   (bk_open[b]),
      .idle   (bk_idle[b])
    );
  end

  assign ba     = {bank_select_bit1, bank_select_bit0};
  assign nopish = (cmd == SPS_NOP) || (cmd == SPS_INH);
  // Internal edge is skipped whenever CKE was low at the previous edge
  assign adv    = cke_prev && (pstate == SPS_RUN || pstate == SPS_SUSP); // RQ9
  assign cmd_ok = cke_prev && cke && (pstate == SPS_RUN); // RQ23
  assign stat   = {22'h0, pdn_over, dpd_short, brst_on, bk_open, pstate};

  // Burst length from mode field; full page wraps until stopped
  function automatic logic [7:0] bl_left(input logic [2:0] f);
    bl_left = (f == 3'h0) ? 8'h00 : (f == 3'h1) ? 8'h01 : (f == 3'h2) ? 8'h03 : 8'h07;
  endfunction

  // Command, burst, power and bus next-state logic
  always_comb begin
    next_pstate = pstate;      next_cfg = cfg;
    next_mode_bl = mode_bl;    next_mode_wbm = mode_wbm;
    next_brst_on = brst_on;    next_brst_wr = brst_wr;     next_brst_ap = brst_ap;
    next_brst_full = brst_full; next_brst_bank = brst_bank; next_brst_col = brst_col;
    next_brst_left = brst_left;
    next_apc_on = apc_on;      next_apc_bank = apc_bank;   next_apc_cnt = apc_cnt;
    next_xsr_cnt = xsr_cnt;    next_nop_cnt = nop_cnt;
    next_dpd_cnt = dpd_cnt;    next_dpd_short = dpd_short;
    next_pdn_cnt = pdn_cnt;    next_pdn_over = pdn_over;
    next_rd_v = rd_v;          next_rd_d = rd_d;
    bk_act = 4'h0; bk_pre = 4'h0; bk_flush = 1'b0;
    wr_en = 1'b0; wr_idx = {brst_bank, brst_col};
    rd_push = 1'b0; rd_idx = {brst_bank, brst_col};
    next_a_wr = 1'b0; next_a_rd = 1'b0; next_a_off = a_off; next_hrdata = hrdata;
    if (adv) begin
      // Pending auto precharge after write recovery
      if (apc_on) begin
        if (apc_cnt == 4'h0) begin
          bk_pre[apc_bank] = 1'b1;
          next_apc_on = 1'b0;
        end else begin
          next_apc_cnt = apc_cnt - 4'h1;
        end
      end
      // Ongoing burst beat, frozen while suspended
      if (brst_on) begin
        wr_en   = brst_wr && !dqm;
        rd_push = !brst_wr;
        next_brst_col = brst_col + 1'b1;
        if (!brst_full) begin
          next_brst_left = brst_left - 8'h01;
          if (brst_left == 8'h01 || brst_left == 8'h00) begin
            next_brst_on = 1'b0;
            if (brst_ap && !brst_wr) bk_pre[brst_bank] = 1'b1;
            if (brst_ap && brst_wr) begin
              next_apc_on = 1'b1;
              next_apc_bank = brst_bank;
              next_apc_cnt = cfg[`SPS_CFG_TWR_LSB +: 4];
            end
          end
        end
      end
    end
    if (cmd_ok) begin
      unique case (cmd)
        SPS_ACT: if (bk_idle[ba]) bk_act[ba] = 1'b1;
        SPS_PRE: begin
          if (addr[`SPS_AP_BIT]) bk_pre = 4'hF; // RQ1 RQ2
          else bk_pre[ba] = 1'b1; // RQ1
          if (addr[`SPS_AP_BIT] || ba == brst_bank) next_brst_on = 1'b0;
        end
        SPS_LMR: begin
          if (&bk_idle) begin
            next_mode_bl  = addr[2:0];
            next_mode_wbm = addr[`SPS_MR_WBM_BIT];
          end
        end
        SPS_BT: next_brst_on = 1'b0;
        SPS_RD, SPS_WR: begin
          if (bk_open[ba]) begin
            wr_en = 1'b0;
            rd_push = 1'b0;
            // Auto-precharging burst in another bank is cut off here
            if (brst_on && brst_ap && brst_bank != ba) begin
              if (!brst_wr) begin
                bk_pre[brst_bank] = 1'b1; // RQ12 RQ13
              end else begin
                next_apc_on = 1'b1; // RQ14 RQ15
                next_apc_bank = brst_bank;
                next_apc_cnt = cfg[`SPS_CFG_TWR_LSB +: 4];
              end
            end
            next_brst_wr   = (cmd == SPS_WR);
            next_brst_ap   = addr[`SPS_AP_BIT];
            next_brst_bank = ba;
            next_brst_col  = addr[CB-1:0] + 1'b1;
            next_brst_full = (mode_bl == `SPS_MR_FULL) && !(cmd == SPS_WR && mode_wbm);
            next_brst_left = (cmd == SPS_WR && mode_wbm) ? 8'h00 : bl_left(mode_bl); // RQ11
            next_brst_on   = next_brst_full || (next_brst_left != 8'h00);
            wr_idx = {ba, addr[CB-1:0]};
            rd_idx = {ba, addr[CB-1:0]};
            if (cmd == SPS_WR) begin
              wr_en = !dqm;
              next_rd_v = '0; // Bus turns round to input
            end else begin
              rd_push = 1'b1;
            end
            if (!next_brst_on && next_brst_ap && cmd == SPS_RD) bk_pre[ba] = 1'b1;
            if (!next_brst_on && next_brst_ap && cmd == SPS_WR) begin
              next_apc_on = 1'b1;
              next_apc_bank = ba;
              next_apc_cnt = cfg[`SPS_CFG_TWR_LSB +: 4];
            end
          end
        end
        default: ;
      endcase
    end
    // Read pipeline carries data out after column latency
    if (adv) begin
      next_rd_v = {next_rd_v[CL-2:0], rd_push};
      for (int i = CL - 1; i > 0; i--) next_rd_d[i] = rd_d[i-1];
      next_rd_d[0] = mem[rd_idx];
    end
    // Power state transitions
    unique case (pstate)
      SPS_RUN: begin
        if (cke_prev && !cke) begin
          if (cmd == SPS_BT && !brst_on) next_pstate = SPS_DPD; // RQ16
          else if (brst_on) next_pstate = SPS_SUSP; // RQ8 RQ19
          else if (cmd == SPS_REF && &bk_idle) next_pstate = SPS_SREF; // RQ19
          else if (nopish) next_pstate = SPS_PDN; // RQ4
        end
        next_pdn_cnt = 32'h0;
        next_dpd_cnt = 11'h0;
      end
      SPS_PDN: begin
        if (cke && nopish) next_pstate = SPS_RUN; // RQ7
        else if (!cke && cmd == SPS_BT && !(|bk_open)) next_pstate = SPS_DPD; // RQ16
        if (pdn_cnt >= 32'(PDN_LIMIT_CYC)) next_pdn_over = 1'b1; // RQ6
        else next_pdn_cnt = pdn_cnt + 32'h1;
      end
      SPS_SUSP: if (cke) next_pstate = SPS_RUN; // RQ10
      SPS_SREF: begin
        if (cke && nopish) begin
          next_pstate  = SPS_SREF_EXIT;
          next_xsr_cnt = cfg[`SPS_CFG_SELF_REFRESH_EXIT_TIME_LSB +: 8];
          next_nop_cnt = 2'h0;
        end
      end
      SPS_SREF_EXIT: begin
        if (xsr_cnt != 8'h0) next_xsr_cnt = xsr_cnt - 8'h01;
        if (cmd == SPS_NOP && nop_cnt != 2'h2) next_nop_cnt = nop_cnt + 2'h1;
        if (xsr_cnt == 8'h0 && nop_cnt == 2'h2) next_pstate = SPS_RUN; // RQ18
      end
      SPS_DPD: begin
        if (dpd_cnt != 11'(`SPS_DPD_MIN_CYC)) next_dpd_cnt = dpd_cnt + 11'h1;
        if (cke) begin
          next_pstate = SPS_RUN;
          bk_flush = 1'b1; // Open rows are lost; the array keeps its contents
          next_brst_on = 1'b0;
          next_apc_on = 1'b0;
          next_dpd_short = (dpd_cnt != 11'(`SPS_DPD_MIN_CYC)); // RQ16
        end
      end
      default: next_pstate = SPS_RUN;
    endcase
    // Zero-wait bus slave: read data is registered in the address phase
    if (hsel && hready && htrans[1]) begin
      next_a_wr  = hwrite;
      next_a_rd  = !hwrite;
      next_a_off = haddr[7:0];
      unique case (haddr[7:0])
        `SPS_REG_CFG:  next_hrdata = cfg;
        `SPS_REG_STAT: next_hrdata = stat;
        `SPS_REG_MODE: next_hrdata = {22'h0, mode_wbm, 6'h0, mode_bl};
        default:       next_hrdata = 32'h0;
      endcase
    end
    if (a_wr && a_off == `SPS_REG_CFG) next_cfg = {16'h0, hwdata[15:0]};
  end

  // Array write path
  always_ff @(posedge clk) begin
    if (ce && wr_en) mem[wr_idx] <= dq_in;
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pstate <= SPS_RUN;   cke_prev <= 1'b0;   cfg <= `SPS_CFG_RST;
      mode_bl <= 3'h0;     mode_wbm <= 1'b0;
      brst_on <= 1'b0;     brst_wr <= 1'b0;    brst_ap <= 1'b0;   brst_full <= 1'b0;
      brst_bank <= 2'h0;   brst_col <= '0;     brst_left <= 8'h00;
      apc_on <= 1'b0;      apc_bank <= 2'h0;   apc_cnt <= 4'h0;
      xsr_cnt <= 8'h00;    nop_cnt <= 2'h0;    dpd_cnt <= 11'h0;  dpd_short <= 1'b0;
      pdn_cnt <= 32'h0;    pdn_over <= 1'b0;   rd_v <= '0;
      for (int i = 0; i < CL; i++) rd_d[i] <= '0;
      a_wr <= 1'b0;        a_rd <= 1'b0;       a_off <= 8'h00;    hrdata <= 32'h0;
    end else if (ce) begin
      pstate <= next_pstate;     cke_prev <= cke;          cfg <= next_cfg;
      mode_bl <= next_mode_bl;   mode_wbm <= next_mode_wbm;
      brst_on <= next_brst_on;   brst_wr <= next_brst_wr;  brst_ap <= next_brst_ap;
      brst_full <= next_brst_full; brst_bank <= next_brst_bank;
      brst_col <= next_brst_col; brst_left <= next_brst_left;
      apc_on <= next_apc_on;     apc_bank <= next_apc_bank; apc_cnt <= next_apc_cnt;
      xsr_cnt <= next_xsr_cnt;   nop_cnt <= next_nop_cnt;
      dpd_cnt <= next_dpd_cnt;   dpd_short <= next_dpd_short;
      pdn_cnt <= next_pdn_cnt;   pdn_over <= next_pdn_over;
      rd_v <= next_rd_v;         rd_d <= next_rd_d;
      a_wr <= next_a_wr;         a_rd <= next_a_rd;        a_off <= next_a_off;
      hrdata <= next_hrdata;
    end
  end

  // Outputs; suspend keeps the last word driven
  assign buf_off      = (pstate == SPS_PDN) || (pstate == SPS_SREF) || (pstate == SPS_DPD); // RQ5
  assign self_refresh = (pstate == SPS_SREF);
  assign dq_out       = rd_d[CL-1];
  assign dq_oe_n      = !rd_v[CL-1] || buf_off; // RQ5
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;

  property p_pre_all;
    @(posedge clk) disable iff (!arst_n) ce && cmd_ok && cmd == SPS_PRE && addr[`SPS_AP_BIT] |=> bk_open == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("all-bank precharge left a row open"); // RQ2
  property p_pdn_in;
    @(posedge clk) disable iff (!arst_n)
      ce && pstate == SPS_RUN && cke_prev && !cke && cmd == SPS_NOP && !brst_on |=> pstate == SPS_PDN;
  endproperty
  a_pdn_in: assert property (p_pdn_in) else $error("power-down not entered"); // RQ4
  property p_buf;
    @(posedge clk) disable iff (!arst_n) pstate == SPS_PDN |-> buf_off && dq_oe_n;
  endproperty
  a_buf: assert property (p_buf) else $error("buffers on in power-down"); // RQ5
  property p_pdn_out;
    @(posedge clk) disable iff (!arst_n) ce && pstate == SPS_PDN && cke && nopish |=> pstate == SPS_RUN;
  endproperty
  a_pdn_out: assert property (p_pdn_out) else $error("power-down exit missed"); // RQ7
  property p_susp;
    @(posedge clk) disable iff (!arst_n) pstate == SPS_SUSP |=> $stable(brst_left) && $stable(dq_out);
  endproperty
  a_susp: assert property (p_susp) else $error("state moved in suspend"); // RQ9
  property p_susp_out;
    @(posedge clk) disable iff (!arst_n) ce && pstate == SPS_SUSP && cke ##1 ce |-> adv;
  endproperty
  a_susp_out: assert property (p_susp_out) else $error("suspend exit not resumed"); // RQ10
  property p_wbm;
    @(posedge clk) disable iff (!arst_n) ce && cmd_ok && cmd == SPS_WR && bk_open[ba] && mode_wbm |=> !brst_on;
  endproperty
  a_wbm: assert property (p_wbm) else $error("write burst longer than one"); // RQ11
  property p_sref_out;
    @(posedge clk) disable iff (!arst_n) pstate == SPS_SREF_EXIT && nop_cnt != 2'h2 |=> pstate != SPS_RUN;
  endproperty
  a_sref_out: assert property (p_sref_out) else $error("self refresh left early"); // RQ18
  property p_gate;
    @(posedge clk) disable iff (!arst_n) ce && !cmd_ok |=> (bk_open & ~$past(bk_open)) == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("command decoded while gated"); // RQ23
endmodule

/* File: tb/sps_mc.sv */
`timescale 1ns/1ns
module sps_mc #(
  parameter int ROW_PRECHARGE_TIME = 4
) (
  // Clock
  input  wire logic        clk,
  // Command pins
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [12:0]      addr,
  output logic             bank_select_bit0,
  output logic             bank_select_bit1,
  output logic             dqm,
  output logic [31:0]      dq_in
);
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, PRE = 4'h2, REF = 4'h1, LMR = 4'h0;

  // Quiet pins until the bench starts issuing
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h0F;
    addr = 13'h0000;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    dqm = 1'b0;
    dq_in = 32'h0000_0000;
  end

  // One command per edge; pins move just after the edge
  task automatic cmd(input logic [3:0] c, input logic [12:0] a, input logic [1:0] b,
                     input logic k, input logic dv, input logic [31:0] d);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    addr <= a;
    {bank_select_bit1, bank_select_bit0} <= b;
    cke <= k;
    dq_in <= dv ? d : ~dq_in; // Released bus toggles so stale data never matches
  endtask

  task automatic nop(input int n, input logic k);
    repeat (n) cmd(NOP, 13'h0000, 2'h0, k, 1'b0, 32'h0);
  endtask

  // Byte mask, moved with the last command
  task automatic mask(input logic m);
    dqm <= m;
  endtask

  // Open a row only in an idle, fully precharged bank
  task automatic act(input logic [1:0] b);
    cmd(ACT, 13'h0000, b, 1'b1, 1'b0, 32'h0);
    nop(1, 1'b1);
  endtask

  // Row precharge wait before the bank is reused
  task automatic pre(input logic [1:0] b, input logic all);
    cmd(PRE, {2'h0, all, 10'h000}, b, 1'b1, 1'b0, 32'h0);
    nop(ROW_PRECHARGE_TIME, 1'b1);
  endtask

  // Mode loads go out only with every bank idle
  task automatic lmr(input logic [12:0] a, input logic [1:0] b);
    pre(2'h0, 1'b1);
    cmd(LMR, a, b, 1'b1, 1'b0, 32'h0);
    nop(2, 1'b1);
  endtask

  // Full restart after deep power-down
  task automatic dpd_exit;
    nop(2000, 1'b1);
    pre(2'h0, 1'b1);
    repeat (2) begin
      cmd(REF, 13'h0000, 2'h0, 1'b1, 1'b0, 32'h0);
      nop(ROW_PRECHARGE_TIME, 1'b1);
    end
    lmr(13'h0002, 2'h0);
    lmr(13'h0000, 2'h2);
  endtask
endmodule

/* File: tb/tb_sps_top.sv */
`timescale 1ns/1ns
module tb_sps_top;
  localparam logic [3:0] RD = 4'h5, WR = 4'h4, NOP = 4'h7, REF = 4'h1, BT = 4'h6;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1, dqm;
  logic [12:0] addr;
  logic [31:0] dq_in, dq_out, hrdata, r;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        dq_oe_n, buf_off, self_refresh, hreadyout, hresp;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        ce = 1'b1;
  int          errors, n_checks;
  logic [31:0] wa [4] = '{32'hA000_0000, 32'hA000_0001, 32'hA000_0002, 32'hA000_0003};
  logic [31:0] wb [4] = '{32'hB000_0000, 32'hC000_0001, 32'hA000_0002, 32'hA000_0003};
  logic [31:0] wc [4] = '{32'hC000_0000, 32'hC000_0001, 32'hA000_0002, 32'hA000_0003};

  always #50 clk = ~clk;

  sps_top #(.PDN_LIMIT_CYC(50)) sps_top_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_bit0(bank_select_bit0),
    .bank_select_bit1(bank_select_bit1), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .buf_off(buf_off), .self_refresh(self_refresh), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  sps_mc sps_mc_i (
    .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .bank_select_bit0(bank_select_bit0), .bank_select_bit1(bank_select_bit1),
    .dqm(dqm), .dq_in(dq_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single AHB-Lite word; hready gates both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    {hsel, htrans, hwrite, hsize} <= {1'b1, 2'h2, w, 3'h2};
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic rs(input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, 32'h4, 32'h0);
    chk(r & m, e);
  endtask

  // Read burst from column zero; optional clock suspend holds the third word
  task automatic rdw(input logic [31:0] e [4], input int sus);
    logic [31:0] q [$];
    int          low;
    low = 0;
    fork
      begin
        sps_mc_i.cmd(RD, 13'h0000, 2'h0, 1'b1, 1'b0, 32'h0);
        sps_mc_i.nop(2, 1'b1);
        sps_mc_i.nop(sus, 1'b0);
        sps_mc_i.nop(14 - sus, 1'b1);
      end
      repeat (16) begin
        @(posedge clk);
        #1;
        if (dq_oe_n === 1'b0) begin
          low++;
          if (q.size() == 0 || q[$] !== dq_out) q.push_back(dq_out);
        end
      end
    join
    chk(low, 4 + sus);
    for (int i = 0; i < 4; i++) chk(q[i], e[i]);
  endtask

  task automatic wr4(input logic [31:0] d [4]);
    sps_mc_i.cmd(WR, 13'h0000, 2'h0, 1'b1, 1'b1, d[0]);
    for (int i = 1; i < 4; i++) sps_mc_i.cmd(NOP, 13'h0000, 2'h0, 1'b1, 1'b1, d[i]);
    sps_mc_i.nop(2, 1'b1);
  endtask

  task automatic t_regs;
    ahb(1'b0, 32'h0, 32'h0);
    chk(r, 32'h0000_0A22);
    ahb(1'b1, 32'h0, 32'h0000_0A23);
    ahb(1'b0, 32'h0, 32'h0);
    chk(r, 32'h0000_0A23);
    ce <= 1'b0;
    ahb(1'b1, 32'h0, 32'h0000_0A24);
    ce <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk(r, 32'h0000_0A23);
    ahb(1'b1, 32'h8, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h8, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 32'h10, 32'h0);
    chk(r, 32'h0);
  endtask

  task automatic t_pre;
    sps_mc_i.cmd(4'hB, 13'h0000, 2'h1, 1'b1, 1'b0, 32'h0);
    sps_mc_i.act(2'h0);
    sps_mc_i.act(2'h2);
    rs(32'h28, 32'h7F);
    sps_mc_i.pre(2'h2, 1'b0);
    rs(32'h08, 32'h7F);
    sps_mc_i.pre(2'h2, 1'b0);
    rs(32'h08, 32'h7F);
    sps_mc_i.act(2'h1);
    sps_mc_i.act(2'h3);
    sps_mc_i.pre(2'h1, 1'b1);
    rs(32'h00, 32'h7F);
  endtask

  // Active power-down, held past the shortened limit on purpose
  task automatic t_pdn;
    sps_mc_i.act(2'h0);
    sps_mc_i.nop(2, 1'b0);
    rs(32'h09, 32'h7F);
    chk({31'h0, buf_off}, 32'h1);
    sps_mc_i.cmd(4'h3, 13'h0000, 2'h1, 1'b0, 1'b0, 32'h0);
    sps_mc_i.nop(50, 1'b0);
    rs(32'h209, 32'h27F);
    sps_mc_i.nop(1, 1'b1);
    sps_mc_i.pre(2'h0, 1'b0);
    rs(32'h00, 32'h7F);
    chk({31'h0, buf_off}, 32'h0);
  endtask

  task automatic t_burst;
    sps_mc_i.lmr(13'h0002, 2'h0);
    sps_mc_i.act(2'h0);
    wr4(wa);
    rdw(wa, 2);
    sps_mc_i.act(2'h1);
    sps_mc_i.cmd(WR, 13'h0400, 2'h0, 1'b1, 1'b1, wc[0]);
    sps_mc_i.cmd(NOP, 13'h0000, 2'h0, 1'b1, 1'b1, wc[1]);
    sps_mc_i.cmd(WR, 13'h0000, 2'h1, 1'b1, 1'b1, 32'hD000_0000);
    sps_mc_i.nop(10, 1'b1);
    rs(32'h10, 32'h7F);
    sps_mc_i.act(2'h0);
    rdw(wc, 0);
    sps_mc_i.cmd(RD, 13'h0400, 2'h0, 1'b1, 1'b0, 32'h0);
    sps_mc_i.cmd(RD, 13'h0000, 2'h1, 1'b1, 1'b0, 32'h0);
    sps_mc_i.nop(10, 1'b1);
    rs(32'h10, 32'h7F);
    sps_mc_i.act(2'h0);
    sps_mc_i.cmd(WR, 13'h0400, 2'h0, 1'b1, 1'b1, wc[0]);
    sps_mc_i.cmd(RD, 13'h0000, 2'h1, 1'b1, 1'b0, 32'h0);
    sps_mc_i.nop(10, 1'b1);
    rs(32'h10, 32'h7F);
    sps_mc_i.lmr(13'h0202, 2'h0);
    sps_mc_i.act(2'h0);
    wr4('{32'hB000_0000, 32'hE000_0001, 32'hE000_0002, 32'hE000_0003});
    rdw(wb, 0);
    sps_mc_i.mask(1'b1);
    wr4(wa);
    sps_mc_i.mask(1'b0);
    rdw(wb, 0);
  endtask

  task automatic t_low;
    sps_mc_i.pre(2'h0, 1'b1);
    sps_mc_i.cmd(REF, 13'h0000, 2'h0, 1'b0, 1'b0, 32'h0);
    sps_mc_i.nop(1, 1'b0);
    rs(32'h03, 32'h7F);
    chk({31'h0, self_refresh}, 32'h1);
    sps_mc_i.nop(14, 1'b1);
    rs(32'h00, 32'h7F);
    chk({31'h0, self_refresh}, 32'h0);
    sps_mc_i.cmd(BT, 13'h0000, 2'h0, 1'b0, 1'b0, 32'h0);
    sps_mc_i.nop(1, 1'b0);
    rs(32'h05, 32'h7F);
    sps_mc_i.nop(1010, 1'b0);
    sps_mc_i.nop(1, 1'b1);
    sps_mc_i.dpd_exit;
    rs(32'h00, 32'h1FF);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    sps_mc_i.nop(2, 1'b1);
    t_regs;
    t_pre;
    t_pdn;
    t_burst;
    t_low;
    print_verdict;
  end

  // Hang guard, about six times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end
endmodule
